// [rtl/hwm_sensor_cfg.sv]
`default_nettype none
// Summary of operation
// - read-only fixed chip identifier, writes ignored
// - cpu diode-mode bit selects compatible diode
// - system diode-mode bit selects compatible diode
// - bit 6 is cpu tach divisor msb
// - bit 5 is system tach divisor msb
// - divisor equals two to the code
// - bit 2 picks cpu diode or thermistor
// - bit 1 picks system diode or thermistor
// - bit 0 enables battery monitor updates
// - bit 5 enables cpu fan protection
// - bit 4 enables system fan protection
// - bit 2 forces cpu current-mode sensing
// - bit 1 forces system current-mode sensing
// - read/write cpu fan maximum output register
// - bank selector picks bank for 50h-5Fh
// - protected fan goes full above critical
module hwm_sensor_cfg
	import hwm_pkg::*;
#(
	parameter logic [7:0] CHIP_ID = 8'h3A // arbitrary value
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [1:0] cpu_tach_div_lo,
	input wire logic [1:0] sys_tach_div_lo,
	input wire logic [7:0] cpu_temp_input,
	input wire logic [7:0] system_temp_input,
	input wire logic [7:0] cpu_crit_temp,
	input wire logic [7:0] sys_crit_temp,
	input wire logic [7:0] cpu_fan_demand,
	input wire logic [7:0] sys_fan_demand,
	input wire logic monitor_cycle_done,
	input wire logic [7:0] vbat_sample,
	output var hwm_sense_e cpu_sense_mode,
	output var hwm_sense_e sys_sense_mode,
	output logic [7:0] cpu_tach_divisor,
	output logic [7:0] sys_tach_divisor,
	output logic [7:0] cpu_fan_output,
	output logic [7:0] system_fan_output,
	output logic [7:0] vbat_reading,
	output logic vbat_valid
);
	logic [7:0] bank_q;
	logic [7:0] diode_q;
	logic [7:0] batt_q;
	logic [7:0] crit_q;
	logic [7:0] fanmax_q;
	logic dph_wr_q;
	logic dph_rd_q;
	logic rd_done_q;
	logic [7:0] idx_q;
	logic [31:0] hrdata_q;
	logic [7:0] vbat_q;
	logic vbat_valid_q;

	wire logic accept;
	wire logic addr_ok;
	wire logic bank0;
	wire logic banked;
	wire logic hit_bank;
	wire logic hit_id;
	wire logic hit_diode;
	wire logic hit_batt;
	wire logic hit_crit;
	wire logic hit_fanmax;
	wire logic [7:0] rd_mux;
	wire logic [7:0] wdata;
	wire logic rd_load;
	wire logic [7:0] cpu_demand;
	wire logic batt_en;
	wire hwm_chan_cfg_s cpu_cfg;
	wire hwm_chan_cfg_s sys_cfg;

	// only word-aligned NONSEQ or SEQ transfers are decoded
	assign accept = hsel & hready & htrans[1];
	assign addr_ok = (haddr[31:HWM_ADDR_TOP] == '0) && (haddr[1:0] == 2'b00);
	assign bank0 = bank_q[HWM_BANK_SEL_MSB:0] == HWM_BANK0;
	assign banked = idx_q[7:4] == HWM_BANKED_HI;
	// other banks are not held here and read as zero
	assign hit_bank = idx_q == HWM_IDX_BANK;
	assign hit_id = idx_q == HWM_IDX_CHIP_ID && bank0;
	assign hit_diode = idx_q == HWM_IDX_DIODE && bank0;
	assign hit_batt = idx_q == HWM_IDX_BATT && bank0;
	assign hit_crit = idx_q == HWM_IDX_CRIT && bank0;
	assign hit_fanmax = idx_q == HWM_IDX_FANMAX;
	assign wdata = hwdata[7:0];
	assign rd_load = dph_rd_q & ~rd_done_q;

	// unmapped or reserved indices read zero
	assign rd_mux = hit_bank ? bank_q :
		hit_id ? CHIP_ID :
		hit_diode ? diode_q :
		hit_batt ? batt_q :
		hit_crit ? crit_q :
		hit_fanmax ? fanmax_q : 8'h00;

	// one wait state on reads keeps read data registered and fresh
	assign hreadyout = ~rd_load;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			dph_wr_q <= 1'b0;
			dph_rd_q <= 1'b0;
			rd_done_q <= 1'b0;
			idx_q <= 8'h00;
			hrdata_q <= 32'h00000000;
		end else begin
			if (hready) begin
				dph_wr_q <= accept & hwrite & addr_ok;
				dph_rd_q <= accept & ~hwrite;
				rd_done_q <= 1'b0;
				if (accept) begin
					idx_q <= addr_ok ? haddr[HWM_IDX_MSB:HWM_IDX_LSB] : 8'h00;
				end
			end else begin
				rd_done_q <= 1'b1;
			end
			if (rd_load) begin
				hrdata_q <= {HWM_RD_PAD, rd_mux};
			end
		end
	end

	// masked merge keeps reserved bits at defaults whatever is written
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bank_q <= HWM_BANK_RST;
			diode_q <= HWM_DIODE_RST;
			batt_q <= HWM_BATT_RST;
			crit_q <= HWM_CRIT_RST;
			fanmax_q <= HWM_FANMAX_RST;
		end else if (dph_wr_q) begin
			if (hit_bank) begin
				bank_q <= hwm_merge(wdata, HWM_BANK_MASK, HWM_BANK_RST);
			end
			if (hit_diode) begin
				diode_q <= hwm_merge(wdata, HWM_DIODE_MASK, HWM_DIODE_RST);
			end
			if (hit_batt) begin
				batt_q <= hwm_merge(wdata, HWM_BATT_MASK, HWM_BATT_RST);
			end
			if (hit_crit) begin
				crit_q <= hwm_merge(wdata, HWM_CRIT_MASK, HWM_CRIT_RST);
			end
			if (hit_fanmax) begin
				fanmax_q <= wdata;
			end
		end
	end

	// battery reading follows the monitor cycle only while enabled
	assign batt_en = batt_q[HWM_BATT_EN];
	always_ff @(posedge core_clk) begin
		if (rst) begin
			vbat_q <= 8'h00;
			vbat_valid_q <= 1'b0;
		end else if (!batt_en) begin
			vbat_valid_q <= 1'b0;
		end else if (monitor_cycle_done) begin
			vbat_q <= vbat_sample;
			vbat_valid_q <= 1'b1;
		end
	end
	assign vbat_reading = vbat_q;
	assign vbat_valid = vbat_valid_q;

	assign cpu_cfg = '{
		sensor_type: batt_q[HWM_BATT_CPU_TYPE],
		diode_mode: diode_q[HWM_DIODE_CPU],
		current_en: crit_q[HWM_CRIT_CPU_CUR],
		crit_en: crit_q[HWM_CRIT_CPU_PROT],
		div_msb: batt_q[HWM_BATT_CPU_DIV]
	};
	assign sys_cfg = '{
		sensor_type: batt_q[HWM_BATT_SYS_TYPE],
		diode_mode: diode_q[HWM_DIODE_SYS],
		current_en: crit_q[HWM_CRIT_SYS_CUR],
		crit_en: crit_q[HWM_CRIT_SYS_PROT],
		div_msb: batt_q[HWM_BATT_SYS_DIV]
	};
	// normal cpu demand is capped, protection still forces full drive
	assign cpu_demand = (cpu_fan_demand > fanmax_q) ?
		fanmax_q : cpu_fan_demand;

	hwm_chan u_cpu_chan (
		.core_clk(core_clk),
		.rst(rst),
		.cfg(cpu_cfg),
		.div_lo(cpu_tach_div_lo),
		.temp(cpu_temp_input),
		.crit_temp(cpu_crit_temp),
		.fan_demand(cpu_demand),
		.sense_mode_q(cpu_sense_mode),
		.divisor_q(cpu_tach_divisor),
		.fan_out_q(cpu_fan_output)
	);

	hwm_chan u_sys_chan (
		.core_clk(core_clk),
		.rst(rst),
		.cfg(sys_cfg),
		.div_lo(sys_tach_div_lo),
		.temp(system_temp_input),
		.crit_temp(sys_crit_temp),
		.fan_demand(sys_fan_demand),
		.sense_mode_q(sys_sense_mode),
		.divisor_q(sys_tach_divisor),
		.fan_out_q(system_fan_output)
	);

	chk_chip_id: assert property (@(posedge core_clk) disable iff (rst)
		rd_load && idx_q == HWM_IDX_CHIP_ID && bank0
		|=> hrdata_q == {24'h000000, CHIP_ID})
		else $error("chip identifier read wrong");
	chk_id_fixed: assert property (@(posedge core_clk) disable iff (rst)
		dph_wr_q && hit_id |=> $stable(batt_q) && $stable(diode_q)
		&& $stable(crit_q) && $stable(bank_q) && $stable(fanmax_q))
		else $error("identifier write disturbed registers");
	chk_bank_gate: assert property (@(posedge core_clk)
		disable iff (rst) rd_load && banked && !bank0
		|=> hrdata_q == 32'h00000000)
		else $error("banked index visible outside bank 0");
	chk_rsvd_bits: assert property (@(posedge core_clk)
		disable iff (rst) dph_wr_q && hit_crit
		|=> crit_q == (($past(hwdata[7:0]) & 8'h36) | 8'h00))
		else $error("reserved bits of critical enable changed");
	chk_read_wait: assert property (@(posedge core_clk) disable iff (rst)
		rd_load |-> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	chk_reset_vals: assert property (@(posedge core_clk)
		rst |=> crit_q == 8'h04 && batt_q == 8'h04 && diode_q == 8'h70)
		else $error("defaults not loaded at reset");
	chk_vbat_update: assert property (@(posedge core_clk)
		disable iff (rst) batt_en && monitor_cycle_done
		|=> vbat_q == $past(vbat_sample) && vbat_valid_q)
		else $error("battery reading not updated");
	chk_fan_cap: assert property (@(posedge core_clk) disable iff (rst)
		!crit_q[HWM_CRIT_CPU_PROT] && cpu_fan_demand > fanmax_q
		|=> cpu_fan_output == $past(fanmax_q))
		else $error("cpu fan exceeds maximum output");

	// expected masks are written out so a wrong package mask still shows
	chk_bank_write: assert property (@(posedge core_clk)
		disable iff (rst) dph_wr_q && hit_bank
		|=> bank_q == ($past(wdata) & 8'h87))
		else $error("bank selector write not masked");
	chk_diode_write: assert property (@(posedge core_clk)
		disable iff (rst) dph_wr_q && hit_diode
		|=> diode_q == (($past(wdata) & 8'h30) | 8'h40))
		else $error("reserved bits of diode selection changed");
	chk_batt_write: assert property (@(posedge core_clk)
		disable iff (rst) dph_wr_q && hit_batt
		|=> batt_q == ($past(wdata) & 8'h67))
		else $error("reserved bits of battery control changed");
	chk_fanmax_write: assert property (@(posedge core_clk)
		disable iff (rst) dph_wr_q && hit_fanmax
		|=> fanmax_q == $past(wdata))
		else $error("fan maximum write lost");
	chk_fanmax_read: assert property (@(posedge core_clk)
		disable iff (rst) rd_load && hit_fanmax
		|=> hrdata_q == {24'h000000, $past(fanmax_q)})
		else $error("fan maximum read wrong");
	chk_hidden_write: assert property (@(posedge core_clk)
		disable iff (rst) dph_wr_q && banked && !bank0
		|=> $stable(diode_q) && $stable(batt_q) && $stable(crit_q))
		else $error("write outside bank 0 reached bank 0 register");
	chk_vbat_off: assert property (@(posedge core_clk)
		disable iff (rst) !batt_en
		|=> !vbat_valid_q)
		else $error("battery reading valid while monitor disabled");
	chk_vbat_hold: assert property (@(posedge core_clk)
		disable iff (rst) !(batt_en && monitor_cycle_done)
		|=> $stable(vbat_q))
		else $error("battery reading changed without monitor cycle");
	chk_cpu_therm: assert property (@(posedge core_clk)
		disable iff (rst)
		!crit_q[HWM_CRIT_CPU_CUR] && !batt_q[HWM_BATT_CPU_TYPE]
		|=> cpu_sense_mode == HWM_SENSE_THERM)
		else $error("cpu thermistor sensing not selected");
	chk_sys_therm: assert property (@(posedge core_clk)
		disable iff (rst)
		!crit_q[HWM_CRIT_SYS_CUR] && !batt_q[HWM_BATT_SYS_TYPE]
		|=> sys_sense_mode == HWM_SENSE_THERM)
		else $error("system thermistor sensing not selected");
	chk_cpu_current: assert property (@(posedge core_clk)
		disable iff (rst) crit_q[HWM_CRIT_CPU_CUR]
		|=> cpu_sense_mode == HWM_SENSE_CURRENT)
		else $error("cpu current mode not selected");
	chk_sys_current: assert property (@(posedge core_clk)
		disable iff (rst) crit_q[HWM_CRIT_SYS_CUR]
		|=> sys_sense_mode == HWM_SENSE_CURRENT)
		else $error("system current mode not selected");
	chk_cpu_div: assert property (@(posedge core_clk)
		disable iff (rst)
		batt_q[HWM_BATT_CPU_DIV] && cpu_tach_div_lo == 2'b11
		|=> cpu_tach_divisor == 8'h80)
		else $error("cpu divisor msb not applied");
	chk_sys_div: assert property (@(posedge core_clk)
		disable iff (rst)
		batt_q[HWM_BATT_SYS_DIV] && sys_tach_div_lo == 2'b00
		|=> sys_tach_divisor == 8'h10)
		else $error("system divisor msb not applied");
endmodule
`default_nettype wire

// [rtl/hwm_pkg.sv]
`default_nettype none
package hwm_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] HWM_IDX_BANK = 8'h4E;
	localparam logic [7:0] HWM_IDX_CHIP_ID = 8'h58;
	localparam logic [7:0] HWM_IDX_DIODE = 8'h59;
	localparam logic [7:0] HWM_IDX_BATT = 8'h5D;
	localparam logic [7:0] HWM_IDX_CRIT = 8'h5E;
	localparam logic [7:0] HWM_IDX_FANMAX = 8'h67;
	localparam logic [3:0] HWM_BANKED_HI = 4'h5;
	localparam logic [2:0] HWM_BANK0 = 3'h0;
	localparam int HWM_IDX_LSB = 2;
	localparam int HWM_IDX_MSB = 9;
	localparam int HWM_ADDR_TOP = 10;

	// reset values and writable masks
	localparam logic [7:0] HWM_BANK_RST = 8'h80;
	localparam logic [7:0] HWM_BANK_MASK = 8'h87;
	localparam logic [7:0] HWM_DIODE_RST = 8'h70;
	localparam logic [7:0] HWM_DIODE_MASK = 8'h30;
	localparam logic [7:0] HWM_BATT_RST = 8'h04;
	localparam logic [7:0] HWM_BATT_MASK = 8'h67;
	localparam logic [7:0] HWM_CRIT_RST = 8'h04;
	localparam logic [7:0] HWM_CRIT_MASK = 8'h36;
	localparam logic [7:0] HWM_FANMAX_RST = 8'hFF;

	// field positions
	localparam int HWM_BANK_SEL_MSB = 2;
	localparam int HWM_DIODE_CPU = 5;
	localparam int HWM_DIODE_SYS = 4;
	localparam int HWM_BATT_CPU_DIV = 6;
	localparam int HWM_BATT_SYS_DIV = 5;
	localparam int HWM_BATT_CPU_TYPE = 2;
	localparam int HWM_BATT_SYS_TYPE = 1;
	localparam int HWM_BATT_EN = 0;
	localparam int HWM_CRIT_CPU_PROT = 5;
	localparam int HWM_CRIT_SYS_PROT = 4;
	localparam int HWM_CRIT_CPU_CUR = 2;
	localparam int HWM_CRIT_SYS_CUR = 1;

	localparam logic [7:0] HWM_FAN_FULL = 8'hFF;
	localparam logic [7:0] HWM_DIV_ONE = 8'h01;
	localparam logic [23:0] HWM_RD_PAD = 24'h000000;

	typedef enum logic [3:0] {
		HWM_SENSE_THERM = 4'b0001,
		HWM_SENSE_DIODE = 4'b0010,
		HWM_SENSE_CURRENT = 4'b0100,
		HWM_SENSE_RSVD = 4'b1000
	} hwm_sense_e;

	typedef struct packed {
		logic sensor_type;
		logic diode_mode;
		logic current_en;
		logic crit_en;
		logic div_msb;
	} hwm_chan_cfg_s;

	function automatic logic [7:0] hwm_div_value(input logic [2:0] code);
		hwm_div_value = HWM_DIV_ONE << code;
	endfunction

	function automatic logic [7:0] hwm_merge(input logic [7:0] data,
		input logic [7:0] mask, input logic [7:0] rstv);
		hwm_merge = (data & mask) | (rstv & ~mask);
	endfunction
endpackage
`default_nettype wire

// [rtl/hwm_chan.sv]
`default_nettype none
module hwm_chan
	import hwm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire hwm_chan_cfg_s cfg,
	input wire logic [1:0] div_lo,
	input wire logic [7:0] temp,
	input wire logic [7:0] crit_temp,
	input wire logic [7:0] fan_demand,
	output var hwm_sense_e sense_mode_q,
	output logic [7:0] divisor_q,
	output logic [7:0] fan_out_q
);
	wire logic over_crit;
	wire logic [2:0] div_code;
	hwm_sense_e sense_d;

	assign over_crit = cfg.crit_en & (temp > crit_temp);
	assign div_code = {cfg.div_msb, div_lo};
	// current mode overrides type and diode selections
	assign sense_d = cfg.current_en ? HWM_SENSE_CURRENT :
		!cfg.sensor_type ? HWM_SENSE_THERM :
		cfg.diode_mode ? HWM_SENSE_DIODE : HWM_SENSE_RSVD;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sense_mode_q <= HWM_SENSE_THERM;
			divisor_q <= HWM_DIV_ONE;
			fan_out_q <= 8'h00;
		end else begin
			sense_mode_q <= sense_d;
			divisor_q <= hwm_div_value(div_code);
			fan_out_q <= over_crit ? HWM_FAN_FULL : fan_demand;
		end
	end

	chk_crit_full: assert property (@(posedge core_clk)
		disable iff (rst)
		cfg.crit_en && temp > crit_temp |=> fan_out_q == 8'hFF)
		else $error("fan not at full drive above critical temperature");
	chk_crit_off: assert property (@(posedge core_clk) disable iff (rst)
		!cfg.crit_en |=> fan_out_q == $past(fan_demand))
		else $error("fan forced while protection disabled");
	chk_div_map: assert property (@(posedge core_clk) disable iff (rst)
		div_code == 3'b100 |=> divisor_q == 8'd16)
		else $error("divisor code 100 does not give 16");
	chk_sense_sel: assert property (@(posedge core_clk)
		disable iff (rst)
		!cfg.current_en && cfg.sensor_type && cfg.diode_mode
		|=> sense_mode_q == HWM_SENSE_DIODE)
		else $error("diode mode not selected");
endmodule
`default_nettype wire

// [test/tb_top.sv]
`default_nettype none
module tb_top
	import hwm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ID_VAL = 8'h5B; // arbitrary value
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [1:0] cpu_lo = 2'h0;
	logic [1:0] sys_lo = 2'h0;
	logic [7:0] cpu_t = 8'h50;
	logic [7:0] sys_t = 8'h50;
	logic [7:0] cpu_c = 8'h40;
	logic [7:0] sys_c = 8'h40;
	logic [7:0] dem = 8'h20;
	logic [7:0] vsamp = 8'h33;
	logic mon_done = 1'b0;
	hwm_sense_e cpu_mode;
	hwm_sense_e sys_mode;
	logic [7:0] cpu_div;
	logic [7:0] sys_div;
	logic [7:0] cpu_out;
	logic [7:0] sys_out;
	logic [7:0] vbat_rd;
	logic vbat_ok;
	logic [31:0] rv;
	int mismatches = 0;
	int n_checks = 0;
	logic [7:0] ridx [6] = '{8'h4E, 8'h58, 8'h59, 8'h5D, 8'h5E, 8'h67};
	logic [7:0] rval [6] = '{8'h80, ID_VAL, 8'h70, 8'h04, 8'h04, 8'hFF};
	logic [7:0] mb [5] = '{8'h04, 8'h06, 8'h06, 8'h00, 8'h00};
	logic [7:0] mc [5] = '{8'h00, 8'h00, 8'h00, 8'h06, 8'h00};
	logic [7:0] md [5] = '{8'h70, 8'h60, 8'h50, 8'h70, 8'h70};
	hwm_sense_e ec [5] = '{HWM_SENSE_DIODE, HWM_SENSE_DIODE, HWM_SENSE_RSVD,
		HWM_SENSE_CURRENT, HWM_SENSE_THERM};
	hwm_sense_e es [5] = '{HWM_SENSE_THERM, HWM_SENSE_RSVD, HWM_SENSE_DIODE,
		HWM_SENSE_CURRENT, HWM_SENSE_THERM};

	hwm_sensor_cfg #(.CHIP_ID(ID_VAL)) hwm_sensor_cfg_inst (
		.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .cpu_tach_div_lo(cpu_lo), .sys_tach_div_lo(sys_lo),
		.cpu_temp_input(cpu_t), .system_temp_input(sys_t),
		.cpu_crit_temp(cpu_c), .sys_crit_temp(sys_c),
		.cpu_fan_demand(dem), .sys_fan_demand(dem),
		.monitor_cycle_done(mon_done), .vbat_sample(vsamp),
		.cpu_sense_mode(cpu_mode), .sys_sense_mode(sys_mode),
		.cpu_tach_divisor(cpu_div), .sys_tach_divisor(sys_div),
		.cpu_fan_output(cpu_out), .system_fan_output(sys_out),
		.vbat_reading(vbat_rd), .vbat_valid(vbat_ok)
	);

	always #5 core_clk = ~core_clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// address phase held until hready, then data phase until hready again
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] wd, output logic [31:0] rd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'hFFFFFF, wd};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d, rv);
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00, rv);
		chk(rv, {24'h0, exp});
	endtask

	// outputs lag register writes by one cycle; three edges is margin
	task automatic settle;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic defaults;
		for (int i = 0; i < 6; i++)
			rdc(ridx[i], rval[i]);
	endtask

	task automatic test_done;
		if (mismatches == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		test_done();
	end

	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		settle();
		chk(32'(cpu_mode), 32'(HWM_SENSE_CURRENT));
		chk(32'(sys_mode), 32'(HWM_SENSE_THERM));
		defaults();
		wr(8'h58, 8'h00);
		rdc(8'h58, ID_VAL);
		wr(8'h59, 8'h00);
		rdc(8'h59, 8'h40);
		wr(8'h5D, 8'hFF);
		rdc(8'h5D, 8'h67);
		wr(8'h5E, 8'hFF);
		rdc(8'h5E, 8'h36);
		wr(8'h5A, 8'hFF);
		rdc(8'h5A, 8'h00);
		rdc(8'h5F, 8'h00);
		// non-zero bank hides 50h-5Fh but not the fan maximum
		wr(8'h4E, 8'hFF);
		rdc(8'h4E, 8'h87);
		rdc(8'h58, 8'h00);
		wr(8'h5D, 8'h00);
		rdc(8'h67, 8'hFF);
		wr(8'h4E, 8'h80);
		rdc(8'h5D, 8'h67);
		for (int i = 0; i < 5; i++) begin
			wr(8'h5D, mb[i]);
			wr(8'h5E, mc[i]);
			wr(8'h59, md[i]);
			settle();
			chk(32'(cpu_mode), 32'(ec[i]));
			chk(32'(sys_mode), 32'(es[i]));
		end
		for (int c = 0; c < 8; c++) begin
			cpu_lo <= 2'(c);
			sys_lo <= 2'(~c);
			wr(8'h5D, {1'b0, c[2], ~c[2], 5'h0});
			settle();
			chk({24'h0, cpu_div}, 32'h1 << c);
			chk({24'h0, sys_div}, 32'h1 << (7 - c));
		end
		settle();
		chk({24'h0, cpu_out}, {24'h0, dem});
		chk({24'h0, sys_out}, {24'h0, dem});
		wr(8'h5E, 8'h30);
		settle();
		chk({24'h0, cpu_out}, 32'hFF);
		chk({24'h0, sys_out}, 32'hFF);
		cpu_t <= 8'h40;
		wr(8'h67, 8'h10);
		rdc(8'h67, 8'h10);
		settle();
		chk({24'h0, cpu_out}, 32'h10);
		chk({24'h0, sys_out}, 32'hFF);
		// protection off: hot inputs keep normal demand, capped on the cpu fan only
		cpu_t <= 8'h50;
		wr(8'h5E, 8'h00);
		settle();
		chk({24'h0, cpu_out}, 32'h10);
		chk({24'h0, sys_out}, {24'h0, dem});
		// a done pulse while disabled must not latch a reading
		wr(8'h5D, 8'h00);
		mon_done <= 1'b1;
		@(posedge core_clk);
		mon_done <= 1'b0;
		settle();
		chk({31'h0, vbat_ok}, 32'h0);
		wr(8'h5D, 8'h01);
		vsamp <= 8'h5A;
		mon_done <= 1'b1;
		@(posedge core_clk);
		mon_done <= 1'b0;
		settle();
		chk({23'h0, vbat_ok, vbat_rd}, 32'h15A);
		wr(8'h5D, 8'h00);
		settle();
		chk({23'h0, vbat_ok, vbat_rd}, 32'h05A);
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		defaults();
		test_done();
	end
endmodule
`default_nettype wire
